//--- src/esf_pkg.sv
// Constants shared by the error status flag logger
package esf_pkg;
	localparam logic [7:0] ESF_CFG_OFFSET = 8'hc8;
	localparam int ESF_REG_W = 16;
	localparam logic [15:0] ESF_RESET_VAL = 16'h0000;
	localparam int ESF_BIT_SBE = 0;
	localparam int ESF_BIT_MBE = 1;
	localparam int ESF_BIT_REFRESH = 8;
	localparam int ESF_BIT_LOCK = 9;
	localparam int ESF_BIT_THERMAL = 11;
	localparam logic [15:0] ESF_IMPL_MASK = 16'h0b03;
	localparam int ESF_REFRESH_LIMIT = 1024;
	localparam int ESF_ADDR_W = 32;
	localparam int ESF_SYN_W = 8;
	localparam int ESF_DST_W = 8;
endpackage

//--- src/esf_refresh_watch.sv
// Pending refresh counter raising a level at the timeout threshold
`timescale 1ns/10ps
module esf_refresh_watch #(
	parameter int LIMIT = esf_pkg::ESF_REFRESH_LIMIT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic refresh_enq,
	input wire logic refresh_deq,
	output logic at_limit
);
	import esf_pkg::*;
	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
	localparam logic [CW-1:0] ONE_C = CW'(1);

	typedef struct packed {
		logic [CW-1:0] pending;
		logic at_limit;
	} esf_rw_state_type;

	esf_rw_state_type st_q, st_d;

	if (LIMIT < 2) begin : g_bad_limit
		$error("LIMIT must be at least 2");
	end

	always_comb begin
		st_d = st_q;
		// Saturate: the queue cannot hold more than the threshold anyway
		if (refresh_enq && !refresh_deq && st_q.pending != LIMIT_C) begin
			st_d.pending = st_q.pending + ONE_C;
		end else if (refresh_deq && !refresh_enq && st_q.pending != '0) begin
			st_d.pending = st_q.pending - ONE_C;
		end
		st_d.at_limit = (st_d.pending == LIMIT_C);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign at_limit = st_q.at_limit;

	a_limit_level: assert property (@(posedge clk) disable iff (!rst_n)
		(refresh_enq && !refresh_deq && st_q.pending == LIMIT_C - ONE_C) |=> at_limit)
		else $error("refresh limit level disagrees with count");
endmodule // esf_refresh_watch

//--- src/esf_logger.sv
// Sticky error status flags, error log lock rules and error message requests
`timescale 1ns/10ps
module esf_logger #(
	parameter int REFRESH_LIMIT = esf_pkg::ESF_REFRESH_LIMIT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [1:0] cfg_be,
	input wire logic [esf_pkg::ESF_REG_W-1:0] cfg_wdata,
	output logic [esf_pkg::ESF_REG_W-1:0] cfg_rdata,
	input wire logic [esf_pkg::ESF_REG_W-1:0] error_message_enables,
	input wire logic global_serr_enable,
	input wire logic thermal_smi_enable,
	input wire logic thermal_sci_enable,
	input wire logic thermal_trip,
	input wire logic locked_nondram_access,
	input wire logic refresh_enq,
	input wire logic refresh_deq,
	input wire logic ecc_single_err,
	input wire logic ecc_multi_err,
	input wire logic [esf_pkg::ESF_ADDR_W-1:0] err_addr,
	input wire logic [esf_pkg::ESF_SYN_W-1:0] err_syndrome,
	input wire logic [esf_pkg::ESF_DST_W-1:0] err_dest,
	output logic [esf_pkg::ESF_REG_W-1:0] error_status_flags,
	output logic [esf_pkg::ESF_ADDR_W-1:0] error_address_log,
	output logic [esf_pkg::ESF_SYN_W-1:0] error_syndrome_log,
	output logic [esf_pkg::ESF_DST_W-1:0] error_destination_log,
	output logic serr_msg,
	output logic smi_msg,
	output logic sci_msg
);
	import esf_pkg::*;

	typedef struct packed {
		logic [ESF_REG_W-1:0] flags;
		logic [ESF_ADDR_W-1:0] addr_log;
		logic [ESF_SYN_W-1:0] syn_log;
		logic [ESF_DST_W-1:0] dst_log;
		logic [ESF_REG_W-1:0] rdata;
		logic serr;
		logic smi;
		logic sci;
	} esf_state_type;

	esf_state_type st_q, st_d;
	logic refresh_limit;
	logic hit;
	logic [ESF_REG_W-1:0] clr_mask;
	logic [ESF_REG_W-1:0] set_vec;
	logic [ESF_REG_W-1:0] rise;
	logic therm_sent;

	if (REFRESH_LIMIT < 2) begin : g_bad_limit
		$error("REFRESH_LIMIT must be at least 2");
	end

	esf_refresh_watch #(.LIMIT(REFRESH_LIMIT)) u_refresh (
		.clk(clk),
		.rst_n(rst_n),
		.refresh_enq(refresh_enq),
		.refresh_deq(refresh_deq),
		.at_limit(refresh_limit)
	);

	always_comb begin
		st_d = st_q;
		hit = (cfg_addr == ESF_CFG_OFFSET);
		// Byte lanes gate the write-one-to-clear; reserved bits masked out
		clr_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & cfg_wdata & ESF_IMPL_MASK;
		if (!(cfg_wr && hit)) begin
			clr_mask = '0;
		end
		// Thermal flag only when some message really goes out, and never twice
		therm_sent = thermal_trip && !st_q.flags[ESF_BIT_THERMAL] && (thermal_smi_enable || thermal_sci_enable
			|| (global_serr_enable && error_message_enables[ESF_BIT_THERMAL]));
		set_vec = '0;
		set_vec[ESF_BIT_THERMAL] = therm_sent;
		set_vec[ESF_BIT_LOCK] = locked_nondram_access;
		set_vec[ESF_BIT_REFRESH] = refresh_limit;
		set_vec[ESF_BIT_MBE] = ecc_multi_err;
		set_vec[ESF_BIT_SBE] = ecc_single_err;
		// Set wins over a clear in the same cycle
		st_d.flags = ((st_q.flags & ~clr_mask) | set_vec) & ESF_IMPL_MASK;
		rise = set_vec & ~st_q.flags;
		st_d.serr = global_serr_enable && |(rise & error_message_enables & ESF_IMPL_MASK);
		st_d.smi = therm_sent && thermal_smi_enable;
		st_d.sci = therm_sent && thermal_sci_enable;
		// Multi-bit logs unless already locked by an earlier multi-bit
		if (ecc_multi_err && !st_q.flags[ESF_BIT_MBE]) begin
			st_d.addr_log = err_addr;
			st_d.syn_log = err_syndrome;
			st_d.dst_log = err_dest;
		end else if (ecc_single_err && !st_q.flags[ESF_BIT_SBE] && !st_q.flags[ESF_BIT_MBE]) begin
			st_d.addr_log = err_addr;
			st_d.syn_log = err_syndrome;
			st_d.dst_log = err_dest;
		end
		st_d.rdata = (cfg_rd && hit) ? (st_q.flags & ESF_IMPL_MASK) : '0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.flags <= ESF_RESET_VAL;
		end else begin
			st_q <= st_d;
		end
	end

	assign cfg_rdata = st_q.rdata;
	assign error_status_flags = st_q.flags;
	assign error_address_log = st_q.addr_log;
	assign error_syndrome_log = st_q.syn_log;
	assign error_destination_log = st_q.dst_log;
	assign serr_msg = st_q.serr;
	assign smi_msg = st_q.smi;
	assign sci_msg = st_q.sci;

	sequence s_mbe_fresh;
		ecc_multi_err && !st_q.flags[ESF_BIT_MBE];
	endsequence

	sequence s_logged_now;
		st_q.flags[ESF_BIT_MBE] && error_address_log == $past(err_addr) && error_syndrome_log == $past(err_syndrome);
	endsequence

	a_serr_on_rise: assert property (@(posedge clk) disable iff (!rst_n)
		(ecc_single_err && !st_q.flags[ESF_BIT_SBE] && global_serr_enable && error_message_enables[ESF_BIT_SBE])
		|=> serr_msg)
		else $error("no error message on flag rise");
	a_serr_quiet_off: assert property (@(posedge clk) disable iff (!rst_n)
		!global_serr_enable |=> !serr_msg)
		else $error("error message sent while globally disabled");
	a_flag_sets: assert property (@(posedge clk) disable iff (!rst_n)
		ecc_multi_err |=> error_status_flags[ESF_BIT_MBE])
		else $error("multi-bit flag not set");
	a_w1c_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_wr && hit && cfg_be[1] && cfg_wdata[ESF_BIT_LOCK] && !locked_nondram_access)
		|=> !error_status_flags[ESF_BIT_LOCK])
		else $error("write of one did not clear flag");
	a_thermal_gate: assert property (@(posedge clk) disable iff (!rst_n)
		(thermal_trip && !thermal_smi_enable && !thermal_sci_enable && !global_serr_enable
		&& !st_q.flags[ESF_BIT_THERMAL]) |=> !error_status_flags[ESF_BIT_THERMAL])
		else $error("thermal flag set without message");
	a_thermal_once: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.flags[ESF_BIT_THERMAL] |=> !smi_msg && !sci_msg)
		else $error("thermal message while flag set");
	a_lock_flag: assert property (@(posedge clk) disable iff (!rst_n)
		locked_nondram_access |=> error_status_flags[ESF_BIT_LOCK])
		else $error("lock flag not set");
	a_refresh_flag: assert property (@(posedge clk) disable iff (!rst_n)
		refresh_limit |=> error_status_flags[ESF_BIT_REFRESH])
		else $error("refresh timeout flag not set");
	a_mbe_log: assert property (@(posedge clk) disable iff (!rst_n)
		s_mbe_fresh |=> s_logged_now)
		else $error("multi-bit error not logged");
	a_mbe_frozen: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.flags[ESF_BIT_MBE] |=> $stable(error_address_log) && $stable(error_syndrome_log)
		&& $stable(error_destination_log))
		else $error("log changed while multi-bit flag set");
	a_sbe_frozen: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q.flags[ESF_BIT_SBE] && !ecc_multi_err) |=> $stable(error_address_log))
		else $error("log changed by single-bit while locked");
	a_sbe_log: assert property (@(posedge clk) disable iff (!rst_n)
		(ecc_single_err && !ecc_multi_err && st_q.flags[1:0] == 2'h0) |=> error_address_log == $past(err_addr))
		else $error("single-bit error not logged");
	a_ecc_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q.flags[ESF_BIT_MBE] && !(cfg_wr && hit && cfg_be[0])) |=> error_status_flags[ESF_BIT_MBE])
		else $error("multi-bit flag lost without clear");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_rdata & ~ESF_IMPL_MASK) == '0 && (error_status_flags & ~ESF_IMPL_MASK) == '0)
		else $error("reserved bits not zero");

	a_sbe_sets: assert property (@(posedge clk) disable iff (!rst_n)
		ecc_single_err |=> error_status_flags[ESF_BIT_SBE])
		else $error("single-bit flag not set");
	a_w1c_zero_keep: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_wr && hit && st_q.flags[ESF_BIT_MBE] && !cfg_wdata[ESF_BIT_MBE])
		|=> error_status_flags[ESF_BIT_MBE])
		else $error("write of zero cleared a flag");
	a_serr_lock: assert property (@(posedge clk) disable iff (!rst_n)
		(locked_nondram_access && !st_q.flags[ESF_BIT_LOCK] && global_serr_enable
		&& error_message_enables[ESF_BIT_LOCK]) |=> serr_msg)
		else $error("no error message on lock flag rise");
	a_serr_gated: assert property (@(posedge clk) disable iff (!rst_n)
		serr_msg |-> $past(global_serr_enable))
		else $error("error message without global enable");
	a_thermal_smi: assert property (@(posedge clk) disable iff (!rst_n)
		(thermal_trip && !st_q.flags[ESF_BIT_THERMAL] && thermal_smi_enable)
		|=> smi_msg && error_status_flags[ESF_BIT_THERMAL])
		else $error("thermal trip gave no SMI request");
	a_thermal_sci: assert property (@(posedge clk) disable iff (!rst_n)
		(thermal_trip && !st_q.flags[ESF_BIT_THERMAL] && thermal_sci_enable)
		|=> sci_msg && error_status_flags[ESF_BIT_THERMAL])
		else $error("thermal trip gave no SCI request");
	a_msg_single: assert property (@(posedge clk) disable iff (!rst_n)
		(smi_msg || sci_msg) |=> !smi_msg && !sci_msg)
		else $error("thermal message repeated");
	a_read_data: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_rd && hit) |=> cfg_rdata == $past(error_status_flags))
		else $error("read data differs from flags");
	a_read_other: assert property (@(posedge clk) disable iff (!rst_n)
		!(cfg_rd && hit) |=> cfg_rdata == '0)
		else $error("read data not zero without a read");
endmodule // esf_logger

//--- verif/esf_hub_model.sv
// Receiving end of the error message requests on the hub link
`timescale 1ns/10ps
module esf_hub_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic serr_msg,
	input wire logic smi_msg,
	input wire logic sci_msg,
	output int serr_count,
	output int smi_count,
	output int sci_count
);
	// Every high cycle counts, so a stretched pulse shows up as extra messages
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serr_count <= 0;
			smi_count <= 0;
			sci_count <= 0;
		end else begin
			serr_count <= serr_count + int'(serr_msg === 1'b1);
			smi_count <= smi_count + int'(smi_msg === 1'b1);
			sci_count <= sci_count + int'(sci_msg === 1'b1);
		end
	end
endmodule // esf_hub_model

//--- verif/tb_top.sv
// Self-checking bench for the error status flag logger
`timescale 1ns/10ps
module tb_top;
	import esf_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [1:0] be = 2'h3;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] ena = 16'h0000;
	logic gen = 1'b0;
	logic smi_en = 1'b0;
	logic sci_en = 1'b0;
	logic [5:0] ev = 6'h00;
	logic [31:0] ea = 32'h0000_0000;
	logic [15:0] rdata;
	logic [15:0] flags;
	logic [31:0] alog;
	logic [7:0] slog;
	logic [7:0] dlog;
	logic serr;
	logic smi;
	logic sci;
	int serr_n;
	int smi_n;
	int sci_n;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	initial forever #10 clk = ~clk;
	esf_logger #(.REFRESH_LIMIT(4)) uut (.clk(clk), .rst_n(rst_n), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr),
		.cfg_be(be), .cfg_wdata(wdata), .cfg_rdata(rdata), .error_message_enables(ena),
		.global_serr_enable(gen), .thermal_smi_enable(smi_en), .thermal_sci_enable(sci_en),
		.thermal_trip(ev[3]), .locked_nondram_access(ev[2]), .refresh_enq(ev[4]), .refresh_deq(ev[5]),
		.ecc_single_err(ev[0]), .ecc_multi_err(ev[1]), .err_addr(ea), .err_syndrome(ea[7:0]),
		.err_dest(ea[15:8]), .error_status_flags(flags), .error_address_log(alog), .error_syndrome_log(slog),
		.error_destination_log(dlog), .serr_msg(serr), .smi_msg(smi), .sci_msg(sci));
	esf_hub_model hub (.clk(clk), .rst_n(rst_n), .serr_msg(serr), .smi_msg(smi), .sci_msg(sci),
		.serr_count(serr_n), .smi_count(smi_n), .sci_count(sci_n));
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask
	task rd_chk(input logic [15:0] e);
		logic [15:0] d;
		reg_rd(ESF_CFG_OFFSET, d);
		check({16'h0000, d}, {16'h0000, e});
		check({16'h0000, flags}, {16'h0000, e});
	endtask
	task reg_wr(input logic [15:0] d, input logic [1:0] b);
		@(negedge clk);
		wr = 1'b1;
		addr = ESF_CFG_OFFSET;
		wdata = d;
		be = b;
		@(negedge clk);
		wr = 1'b0;
		be = 2'h3;
	endtask
	// Event pulses: 0 single, 1 multi, 2 lock, 3 thermal, 4 enqueue, 5 retire
	task fire(input logic [5:0] e, input logic [31:0] a);
		@(negedge clk);
		ev = e;
		ea = a;
		@(negedge clk);
		ev = 6'h00;
	endtask
	task logs(input logic [31:0] a);
		check(alog, a);
		check({16'h0000, dlog, slog}, {16'h0000, a[15:0]});
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			end_sim;
		end
	end
	initial begin
		logic [15:0] d;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		rd_chk(ESF_RESET_VAL);
		reg_rd(8'hca, d);
		check({16'h0000, d}, 32'h0000_0000);
		ena = 16'h0303;
		gen = 1'b1;
		fire(6'h02, 32'h1111_2233);
		rd_chk(16'h0002);
		logs(32'h1111_2233);
		fire(6'h01, 32'h4444_5566);
		rd_chk(16'h0003);
		logs(32'h1111_2233);
		check(serr_n, 2);
		reg_wr(16'h0003, 2'h3);
		fire(6'h01, 32'h7777_8899);
		logs(32'h7777_8899);
		fire(6'h01, 32'h0000_aabb);
		logs(32'h7777_8899);
		fire(6'h02, 32'hcccc_ddee);
		rd_chk(16'h0003);
		logs(32'hcccc_ddee);
		fire(6'h02, 32'h1234_5678);
		logs(32'hcccc_ddee);
		reg_wr(16'h0001, 2'h3);
		rd_chk(16'h0002);
		fire(6'h01, 32'h0f0f_1e1e);
		logs(32'hcccc_ddee);
		@(negedge clk);
		check(serr_n, 5);
		reg_wr(16'h0003, 2'h3);
		gen = 1'b0;
		fire(6'h04, 32'h0000_0000);
		rd_chk(16'h0200);
		check(serr_n, 5);
		reg_wr(16'hf4fc, 2'h3);
		reg_wr(16'h0200, 2'h1);
		rd_chk(16'h0200);
		reg_wr(16'h0200, 2'h3);
		ena = 16'h0200;
		gen = 1'b1;
		fire(6'h04, 32'h0000_0000);
		reg_wr(16'h0200, 2'h3);
		check(serr_n, 6);
		ena = 16'h0000;
		fire(6'h08, 32'h0000_0000);
		rd_chk(16'h0000);
		smi_en = 1'b1;
		fire(6'h08, 32'h0000_0000);
		rd_chk(16'h0800);
		fire(6'h08, 32'h0000_0000);
		@(negedge clk);
		check(smi_n, 1);
		reg_wr(16'h0800, 2'h3);
		smi_en = 1'b0;
		sci_en = 1'b1;
		fire(6'h08, 32'h0000_0000);
		@(negedge clk);
		check(sci_n, 1);
		check(smi_n, 1);
		reg_wr(16'h0800, 2'h3);
		sci_en = 1'b0;
		ena = 16'h0900;
		fire(6'h08, 32'h0000_0000);
		rd_chk(16'h0800);
		check(serr_n, 7);
		reg_wr(16'h0800, 2'h3);
		repeat (3) fire(6'h10, 32'h0000_0000);
		repeat (2) @(negedge clk);
		rd_chk(16'h0000);
		fire(6'h10, 32'h0000_0000);
		repeat (2) @(negedge clk);
		rd_chk(16'h0100);
		check(serr_n, 8);
		repeat (4) fire(6'h20, 32'h0000_0000);
		reg_wr(16'h0100, 2'h3);
		rd_chk(16'h0000);
		fire(6'h02, 32'h5a5a_a5a5);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd_chk(ESF_RESET_VAL);
		logs(32'h0000_0000);
		end_sim;
	end
endmodule // tb_top
